/* core/jss_defs.vh */
// Constants for the job status word sequencer
`ifndef JSS_DEFS_VH
`define JSS_DEFS_VH
// APB register byte offsets
`define JSS_OFF_CTRL      12'h000
`define JSS_OFF_STATUS    12'h004
`define JSS_OFF_COUNT     12'h008
`define JSS_OFF_EVENT     12'h00c
`define JSS_OFF_PERR      12'h010
`define JSS_OFF_OVWR      12'h014
// Control register fields
`define JSS_CTRL_JOB_LSB  0
`define JSS_CTRL_JOB_MSB  1
`define JSS_CTRL_RESP_BIT 2
// Event register fields (write one to fire)
`define JSS_EV_READY      0
`define JSS_EV_TRIG_SEND  1
`define JSS_EV_TRIG_RECV  2
`define JSS_EV_DONE       3
`define JSS_EV_FAIL       4
// Error nibble position in the first word
`define JSS_ERR_LSB       8
`define JSS_ERR_MSB       11
// Job kinds
`define JSS_JOB_MGMT      2'h0
`define JSS_JOB_OUTBITS   2'h1
`define JSS_JOB_INBITS    2'h2
// Status word values
`define JSS_SW_COLD       16'h000a
`define JSS_SW_SEND_EN    16'h0008
`define JSS_SW_RECV_EN    16'h000b
`define JSS_SW_MGMT_ACT   16'h0022
`define JSS_SW_ACK_RDY    16'h0023
`define JSS_SW_ACK_OK     16'h0066
`define JSS_SW_ACK_OK_EN  16'h0064
`define JSS_SW_ACK_ERR    16'h006a
`define JSS_SW_ACK_ERR_EN 16'h0068
`define JSS_SW_OUT_DONE   16'h0026
`define JSS_SW_DONE_SEND  16'h0004
`define JSS_SW_IN_DONE    16'h0046
`define JSS_SW_DONE_RECV  16'h0005
`define JSS_SW_EDGE_MGMT  16'h0002
`define JSS_SW_EDGE_BITS  16'h0006
// Firmware cycle: 6 ms at 25 ns per clock
`define JSS_FW_CYCLES     24'h03a980
`endif

/* core/jss_sync.v */
// Two-flop synchroniser for an active-low reset release
module jss_sync (
    // Clock and raw reset
    input  wire sys_clk_i,
    input  wire nrst_i,
    // Released reset
    output wire nrst_o
);
    reg [1:0] sync_q;

    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sync_q <= 2'h0;
        else
            sync_q <= {sync_q[0], 1'b1};
    end

    assign nrst_o = sync_q[1];
endmodule // jss_sync

/* core/jss_timer.v */
// Firmware-cycle timer: counts down after start, pulses done at zero
module jss_timer #(
    parameter [23:0] CYCLES = 24'h03a980
) (
    // Clock and reset
    input  wire sys_clk_i,
    input  wire nrst_i,
    // Control
    input  wire start_i,
    output reg  done_o
);
    reg [23:0] cnt_q;
    reg        run_q;

    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q  <= 24'h0;
            run_q  <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                // Start, done and the status move take three edges; CYCLES must be at least 3
                cnt_q <= CYCLES - 24'h3;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                if (cnt_q == 24'h0)
                begin
                    run_q  <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                    cnt_q <= cnt_q - 24'h1;
            end
        end
    end
endmodule // jss_timer

/* core/jss_seq.v */
// Job status word sequencer with APB register access
//
// Added by the designer: the placing of the registers and register access over APB.
`include "jss_defs.vh"

// How it works
// - After reset the status reads 000a 0000: cold restart, both directions off.
// - Ready event for send jobs gives 0008 0000, send enabled.
// - Ready event for input-bit read gives 000b 0000, receive enabled.
// - Management send trigger gives 0022 with the sent byte count.
// - Management job without response takes no receive; the send is acknowledged.
// - Management job without response finishes at 0004 0000.
// - With response, the device prepares it and a receive fetches it.
// - Response ready gives 0023 0000, receive enabled.
// - Successful response receive gives 0066 with the byte count read.
// - Within one 6 ms firmware cycle this turns to 0064, count kept.
// - Failed response gives 0x6a then 0x68, count kept.
// - Output-bit send trigger gives 0026 with the byte count at once.
// - After output-bit send, 0004 0000 within one firmware cycle.
// - Input-bit receive trigger gives 0046 with the byte count read.
// - After input-bit read, 0005 0000 within one firmware cycle.
// - Status bits 8 to 11 hold the error code given with the fail completion event, shown once the response receive comes.
module jss_seq #(
    // Firmware cycle length in clocks; only simulation should shorten it
    parameter [23:0] FW_CYCLES = `JSS_FW_CYCLES
) (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // Status record
    output reg  [15:0] job_status_word_o,
    output reg  [15:0] byte_count_o,
    output reg  [7:0]  param_error_byte_o
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_COLD     = 4'h0;
    localparam [3:0] ST_SEND_EN  = 4'h1;
    localparam [3:0] ST_RECV_EN  = 4'h2;
    localparam [3:0] ST_MGMT_ACT = 4'h3;
    localparam [3:0] ST_ACK_RDY  = 4'h4;
    localparam [3:0] ST_ACK_END  = 4'h5;
    localparam [3:0] ST_BIT_END  = 4'h6;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    wire rst_n;

    jss_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .nrst_o    (rst_n)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [3:0]  state_q;
    reg  [1:0]  job_q;
    reg         resp_q;
    reg  [3:0]  err_q;
    reg         tmr_start_q;
    wire        tmr_done;

    // Address decode used for both read mux and write strobes
    function [2:0] reg_index;
        input [11:0] addr;
        begin
            case (addr)
                `JSS_OFF_CTRL:   reg_index = 3'h1;
                `JSS_OFF_STATUS: reg_index = 3'h2;
                `JSS_OFF_COUNT:  reg_index = 3'h3;
                `JSS_OFF_EVENT:  reg_index = 3'h4;
                `JSS_OFF_PERR:   reg_index = 3'h5;
                `JSS_OFF_OVWR:   reg_index = 3'h6;
                default:         reg_index = 3'h0;
            endcase
        end
    endfunction

    // Input-bit read jobs run the receive direction; every other job sends
    function is_read_job;
        input [1:0] job;
        begin
            is_read_job = (job == `JSS_JOB_INBITS);
        end
    endfunction

    wire [2:0]  idx    = reg_index(paddr_i);
    // One wait state: the access is taken at its first edge, pready follows a cycle later
    wire        access = psel_i & penable_i & ~pready_o;
    wire        wr     = access & pwrite_i;
    wire        ev_wr  = wr & (idx == 3'h4);

    // ------------------------------------------------------------
    // Event strobes
    // ------------------------------------------------------------
    // Several event bits may arrive in one write; each gets its own strobe
    wire [4:0]  ev_vec;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_ev
            assign ev_vec[g] = ev_wr & pwdata_i[g];
        end
    endgenerate

    wire        ev_ready = ev_vec[`JSS_EV_READY];
    wire        ev_send  = ev_vec[`JSS_EV_TRIG_SEND];
    wire        ev_recv  = ev_vec[`JSS_EV_TRIG_RECV];
    wire        ev_done  = ev_vec[`JSS_EV_DONE];
    wire        ev_fail  = ev_vec[`JSS_EV_FAIL];

    // ------------------------------------------------------------
    // Edge-generation overwrite
    // ------------------------------------------------------------
    // Only the edge value of the running job is taken, for a management job only without response; anything else is dropped
    wire        ow_wr    = wr & (idx == 3'h6);
    wire        ow_mgmt  = ow_wr & (state_q == ST_MGMT_ACT) & ~resp_q & (pwdata_i[15:0] == `JSS_SW_EDGE_MGMT);
    wire        ow_bits  = ow_wr & (state_q == ST_BIT_END) & (pwdata_i[15:0] == `JSS_SW_EDGE_BITS);

    // ------------------------------------------------------------
    // Firmware-cycle timer
    // ------------------------------------------------------------
    // Counts one firmware cycle from the completing transfer to the re-enable
    jss_timer #(
        .CYCLES (FW_CYCLES)
    ) u_timer (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (rst_n),
        .start_i   (tmr_start_q),
        .done_o    (tmr_done)
    );

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end
        else
        begin
            pready_o  <= access;
            pslverr_o <= access & (idx == 3'h0);
            // Read data is taken with the access, so it stands when pready is seen
            if (access & ~pwrite_i)
            begin
                case (idx)
                    3'h1:    prdata_o <= {29'h0, resp_q, job_q};
                    3'h2:    prdata_o <= {16'h0, job_status_word_o};
                    3'h3:    prdata_o <= {16'h0, byte_count_o};
                    3'h5:    prdata_o <= {24'h0, param_error_byte_o};
                    default: prdata_o <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control and parameter error byte
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            job_q              <= `JSS_JOB_MGMT;
            resp_q             <= 1'b0;
            param_error_byte_o <= 8'h0;
        end
        else
        begin
            if (wr & (idx == 3'h1))
            begin
                job_q  <= pwdata_i[`JSS_CTRL_JOB_MSB:`JSS_CTRL_JOB_LSB];
                resp_q <= pwdata_i[`JSS_CTRL_RESP_BIT];
            end
            // Bit 0 flag, bits 1..3 forced unused, bits 7..4 error number
            if (wr & (idx == 3'h5))
                param_error_byte_o <= {pwdata_i[7:4], 3'h0, pwdata_i[0]};
        end
    end

    // ------------------------------------------------------------
    // Status sequencer
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q           <= ST_COLD;
            job_status_word_o <= `JSS_SW_COLD;
            byte_count_o      <= 16'h0;
            err_q             <= 4'h0;
            tmr_start_q       <= 1'b0;
        end
        else
        begin
            tmr_start_q <= 1'b0;
            // Software edge-generation overwrite; data-area bit 7 is never set here
            if (ow_mgmt)
            begin
                job_status_word_o <= `JSS_SW_EDGE_MGMT;
                byte_count_o      <= 16'h0;
            end
            else if (ow_bits)
            begin
                job_status_word_o <= `JSS_SW_EDGE_BITS;
                byte_count_o      <= 16'h0;
            end
            case (state_q)
                ST_COLD:
                begin
                    if (ev_ready)
                    begin
                        if (is_read_job(job_q))
                        begin
                            state_q           <= ST_RECV_EN;
                            job_status_word_o <= `JSS_SW_RECV_EN;
                        end
                        else
                        begin
                            state_q           <= ST_SEND_EN;
                            job_status_word_o <= `JSS_SW_SEND_EN;
                        end
                        byte_count_o <= 16'h0;
                    end
                end
                ST_SEND_EN:
                begin
                    if (ev_send)
                    begin
                        byte_count_o <= pwdata_i[31:16];
                        if (job_q == `JSS_JOB_OUTBITS)
                        begin
                            state_q           <= ST_BIT_END;
                            job_status_word_o <= `JSS_SW_OUT_DONE;
                            tmr_start_q       <= 1'b1;
                        end
                        else
                        begin
                            state_q           <= ST_MGMT_ACT;
                            job_status_word_o <= `JSS_SW_MGMT_ACT;
                        end
                    end
                end
                ST_RECV_EN:
                begin
                    if (ev_recv)
                    begin
                        state_q           <= ST_BIT_END;
                        job_status_word_o <= `JSS_SW_IN_DONE;
                        byte_count_o      <= pwdata_i[31:16];
                        tmr_start_q       <= 1'b1;
                    end
                end
                ST_MGMT_ACT:
                begin
                    // Receive triggers are ignored here: no response is pending
                    if (ev_done | ev_fail)
                    begin
                        if (resp_q)
                        begin
                            state_q           <= ST_ACK_RDY;
                            job_status_word_o <= `JSS_SW_ACK_RDY;
                            err_q             <= ev_fail ? pwdata_i[11:8] : 4'h0;
                        end
                        else
                        begin
                            state_q           <= ST_SEND_EN;
                            job_status_word_o <= `JSS_SW_DONE_SEND;
                        end
                        byte_count_o <= 16'h0;
                    end
                end
                ST_ACK_RDY:
                begin
                    if (ev_recv)
                    begin
                        state_q      <= ST_ACK_END;
                        byte_count_o <= pwdata_i[31:16];
                        tmr_start_q  <= 1'b1;
                        // The error nibble latched at completion shows only now, beside the count
                        if (err_q == 4'h0)
                            job_status_word_o <= `JSS_SW_ACK_OK;
                        else
                            job_status_word_o <= `JSS_SW_ACK_ERR | {4'h0, err_q, 8'h0};
                    end
                end
                ST_ACK_END:
                begin
                    if (tmr_done)
                    begin
                        state_q           <= ST_SEND_EN;
                        // Clearing bit 1 keeps error nibble and count
                        job_status_word_o <= job_status_word_o & 16'hfffd;
                    end
                end
                ST_BIT_END:
                begin
                    if (tmr_done)
                    begin
                        byte_count_o <= 16'h0;
                        if (is_read_job(job_q))
                        begin
                            state_q           <= ST_RECV_EN;
                            job_status_word_o <= `JSS_SW_DONE_RECV;
                        end
                        else
                        begin
                            state_q           <= ST_SEND_EN;
                            job_status_word_o <= `JSS_SW_DONE_SEND;
                        end
                    end
                end
                default:
                begin
                    state_q           <= ST_COLD;
                    job_status_word_o <= `JSS_SW_COLD;
                end
            endcase
        end
    end
endmodule // jss_seq

/* dv/jss_seq_properties.sv */
// Port assertions for the job status word sequencer
module jss_seq_props #(
    parameter int FW_MAX = 240000
) (
    // Clock, reset and APB
    input wire        sys_clk_i,
    input wire        nrst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    // Status record
    input wire [15:0] job_status_word_o,
    input wire [15:0] byte_count_o,
    input wire [7:0]  param_error_byte_o
);
    wire        acc    = psel_i & penable_i;
    wire        wr_acc = acc & pwrite_i;
    wire [15:0] ev_len = pwdata_i[31:16];
    wire [15:0] sw     = job_status_word_o;
    wire        busy   = (sw inside {16'h0066, 16'h0026, 16'h0046, 16'h0006}) || (sw[7:0] == 8'h6a);
    logic [17:0] fw_cnt_q;
    // Saturates so a stuck status cannot wrap back under the bound
    always @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
            fw_cnt_q <= 18'h0;
        else if (!busy)
            fw_cnt_q <= 18'h0;
        else if (fw_cnt_q != 18'h3ffff)
            fw_cnt_q <= fw_cnt_q + 18'h1;
    // ----
    // Checks
    // ----
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    pready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready held beyond one cycle");
    pready_cause_a: assert property ($rose(pready_o) |-> $past(acc))
        else $error("pready without an access phase");
    slverr_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("pslverr outside pready");
    bit7_clear_a: assert property (!sw[7])
        else $error("status bit 7 set");
    perr_unused_a: assert property (param_error_byte_o[3:1] == 3'h0)
        else $error("error byte bits 3 to 1 set");
    idle_count_zero_a: assert property ((sw inside {16'h000a, 16'h0008, 16'h000b, 16'h0023, 16'h0004, 16'h0005,
        16'h0002, 16'h0006}) |-> byte_count_o == 16'h0000)
        else $error("byte count not zero");
    len_capture_a: assert property ($changed(sw) && (sw inside {16'h0022, 16'h0026, 16'h0046, 16'h0066})
        |-> byte_count_o == $past(ev_len))
        else $error("byte count not taken from event");
    err_nibble_a: assert property ($changed(sw) && sw[7:0] == 8'h6a
        |-> sw[11:8] != 4'h0 && byte_count_o == $past(ev_len))
        else $error("error completion malformed");
    count_kept_a: assert property ($changed(sw) && (sw[7:0] inside {8'h64, 8'h68})
        |-> $stable(byte_count_o))
        else $error("byte count lost on re-enable");
    enable_access_a: assert property ($changed(sw) && (sw inside {16'h0008, 16'h000b})
        |-> $past(wr_acc))
        else $error("enable without a write");
    fw_bound_a: assert property (fw_cnt_q <= FW_MAX)
        else $error("re-enable later than one firmware cycle");
    cover property (sw == 16'h0066);
    cover property (sw[7:0] == 8'h6a);
    cover property (sw == 16'h0046);
    cover property (sw[7:0] == 8'h64);
endmodule // jss_seq_props

bind jss_seq jss_seq_props #(.FW_MAX(FW_CYCLES)) u_props (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .job_status_word_o(job_status_word_o),
    .byte_count_o(byte_count_o), .param_error_byte_o(param_error_byte_o));

/* dv/jss_host.sv */
// Controller-side APB master model driving the sequencer
module jss_host (
    // Clock
    input  wire logic        clk_i,
    // APB request
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [11:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    // APB answer
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 12'h000;
        pwdata_o  = 32'h0;
    end
    // Carries the controller's events, status overwrites and error bytes
    // Request held until pready is sampled high; gives up after 64 edges
    task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        begin
            ok = 1'b0;
            @(posedge clk_i);
            psel_o    <= 1'b1;
            pwrite_o  <= wr;
            paddr_o   <= adr;
            pwdata_o  <= wd;
            @(posedge clk_i);
            penable_o <= 1'b1;
            for (n = 0; n < 64 && !ok; n++)
            begin
                @(posedge clk_i);
                ok = (pready_i === 1'b1);
            end
            rd        = prdata_i;
            err       = pslverr_i;
            psel_o    <= 1'b0;
            penable_o <= 1'b0;
        end
    endtask
endmodule // jss_host

/* dv/jss_seq_bench.sv */
// Self-checking bench for the job status word sequencer
module jss_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic rst; logic [11:0] adr; logic [31:0] wd; logic [15:0] sw; logic [15:0] cnt;} jss_row_t;
    logic        sys_clk_i;
    logic        nrst_i;
    logic        psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] sw, cnt;
    logic [7:0]  perr;
    int          error_cnt = 0;
    int          cmp_count = 0;
    logic [3:0]  codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc};
    // Rows: reset first, register written (fff waits for the firmware cycle), then status and count expected
    jss_row_t rows [28] = '{
        '{1'b1, 12'h000, 32'h00000000, 16'h000a, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000001, 16'h0008, 16'h0000},
        '{1'b0, 12'h00c, 32'h00050002, 16'h0022, 16'h0005},
        '{1'b0, 12'h00c, 32'h00090004, 16'h0022, 16'h0005},
        '{1'b0, 12'h014, 32'h00000002, 16'h0002, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000008, 16'h0004, 16'h0000},
        '{1'b1, 12'h000, 32'h00000004, 16'h000a, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000001, 16'h0008, 16'h0000},
        '{1'b0, 12'h00c, 32'h00030002, 16'h0022, 16'h0003},
        '{1'b0, 12'h014, 32'h00000002, 16'h0022, 16'h0003},
        '{1'b0, 12'h00c, 32'h00000008, 16'h0023, 16'h0000},
        '{1'b0, 12'h00c, 32'h00070004, 16'h0066, 16'h0007},
        '{1'b0, 12'hfff, 32'h00000000, 16'h0064, 16'h0007},
        '{1'b1, 12'h000, 32'h00000004, 16'h000a, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000001, 16'h0008, 16'h0000},
        '{1'b0, 12'h00c, 32'h00030002, 16'h0022, 16'h0003},
        '{1'b0, 12'h00c, 32'h00000910, 16'h0023, 16'h0000},
        '{1'b0, 12'h00c, 32'h00020004, 16'h096a, 16'h0002},
        '{1'b0, 12'hfff, 32'h00000000, 16'h0968, 16'h0002},
        '{1'b1, 12'h000, 32'h00000001, 16'h000a, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000001, 16'h0008, 16'h0000},
        '{1'b0, 12'h00c, 32'h00040002, 16'h0026, 16'h0004},
        '{1'b0, 12'h014, 32'h00000006, 16'h0006, 16'h0000},
        '{1'b0, 12'hfff, 32'h00000000, 16'h0004, 16'h0000},
        '{1'b1, 12'h000, 32'h00000002, 16'h000a, 16'h0000},
        '{1'b0, 12'h00c, 32'h00000001, 16'h000b, 16'h0000},
        '{1'b0, 12'h00c, 32'h00060004, 16'h0046, 16'h0006},
        '{1'b0, 12'h014, 32'h00000006, 16'h0006, 16'h0000}};

    // A short firmware cycle keeps the re-enable paths within the run
    jss_seq #(.FW_CYCLES(24'h000020)) uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .job_status_word_o(sw), .byte_count_o(cnt), .param_error_byte_o(perr));
    jss_host host (.clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // ----
    // Tasks
    // ----
    task automatic results;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                $display("wrong value %s expected %h seen %h", what, exp, got);
                error_cnt++;
            end
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                $display("wrong value %s expected %b seen %b", what, exp, got);
                error_cnt++;
            end
        end
    endtask
    // A handshake that never completes ends the run as a mismatch
    task automatic bus(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        logic ok;
        begin
            host.xfer(wr, adr, wd, rdat, serr, ok);
            if (ok !== 1'b1)
            begin
                $display("wrong value handshake expected 1 seen %b", ok);
                error_cnt++;
                results();
            end
            #1;
        end
    endtask
    // Waits for the firmware-cycle move; a status that never moves ends the run
    task automatic settle;
        logic [15:0] was;
        int          n;
        begin
            was = sw;
            for (n = 0; n < 64 && sw === was; n++)
                @(posedge sys_clk_i);
            if (sw === was)
            begin
                $display("wrong value status move expected change seen %h", sw);
                error_cnt++;
                results();
            end
            #1;
        end
    endtask
    // Reset is asserted mid-run too; first setup waits out the two-flop release
    task automatic do_reset;
        begin
            @(posedge sys_clk_i);
            nrst_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            nrst_i <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        nrst_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        foreach (rows[i])
        begin
            if (rows[i].rst)
                do_reset();
            if (rows[i].adr == 12'hfff)
                settle();
            else
                bus(1'b1, rows[i].adr, rows[i].wd);
            chk16("status word", rows[i].sw, sw);
            chk16("byte count", rows[i].cnt, cnt);
            bus(1'b0, 12'h004, 32'h0);
            chk16("status read", rows[i].sw, rdat[15:0]);
            bus(1'b0, 12'h008, 32'h0);
            chk16("count read", rows[i].cnt, rdat[15:0]);
        end
        bus(1'b1, 12'h014, 32'h00000002);
        chk16("refused overwrite", 16'h0006, sw);
        settle();
        chk16("read job re-enable", 16'h0005, sw);
        chk16("read job count", 16'h0000, cnt);
        foreach (codes[i])
        begin
            bus(1'b1, 12'h010, {24'h0, codes[i], 3'h0, codes[i] != 4'h0});
            chk16("error byte", {8'h00, codes[i], 3'h0, codes[i] != 4'h0}, {8'h00, perr});
        end
        bus(1'b1, 12'h010, 32'h000000ff);
        bus(1'b0, 12'h010, 32'h0);
        chk16("error byte read", 16'h00f1, rdat[15:0]);
        chk1("mapped slave error", 1'b0, serr);
        bus(1'b0, 12'h018, 32'h0);
        chk1("unmapped slave error", 1'b1, serr);
        results();
    end
endmodule // jss_seq_bench
